//--- design/wit_defs.svh
`ifndef WIT_DEFS_SVH
`define WIT_DEFS_SVH

// ***********************************************************************
// Register byte addresses
// ***********************************************************************
`define WIT_MODE_ADDR      32'h0FFFF680
`define WIT_STATUS_ADDR    32'h0FFFF684
`define WIT_CLEAR_ADDR     32'h0FFFF688
`define WIT_IRQ_EN_ADDR    32'h0FFFF68C

// ***********************************************************************
// Reset values
// ***********************************************************************
`define WIT_MODE_RESET     8'h00
`define WIT_STATUS_RESET   3'h0
`define WIT_IRQ_EN_RESET   3'h0

// ***********************************************************************
// Mode register field positions
// ***********************************************************************
`define WIT_ENABLE_BIT     0
`define WIT_START_BIT      1
`define WIT_FLAG_LSB       2
`define WIT_FLAG_MSB       3
`define WIT_EXP_LSB        4
`define WIT_EXP_MSB        6
`define WIT_SOURCE_BIT     7

// ***********************************************************************
// Event bit positions and chain taps
// ***********************************************************************
`define WIT_EV_WATCH       0
`define WIT_EV_INTERVAL    1
`define WIT_EV_COUNT       2
`define WIT_EXP_BASE       4
`define WIT_COUNTER_TAP    9
`define WIT_FLAG_SHORT_TAP 5
`define WIT_FLAG_MIN_TAP   4

`endif

//--- design/wit_pkg.sv
package wit_pkg;

   // Watch flag period selection, encoded as in the mode register
   typedef enum logic [1:0] {
      WIT_FLAG_2P14 = 2'h0,
      WIT_FLAG_2P13 = 2'h1,
      WIT_FLAG_2P5  = 2'h2,
      WIT_FLAG_2P4  = 2'h3
   } wit_flag_type;

   // Watch clock source
   typedef enum logic {
      WIT_SRC_SUB_OSC = 1'b0,
      WIT_SRC_DIVIDED = 1'b1
   } wit_source_type;

endpackage

//--- design/wit_chain_if.sv
interface wit_chain_if #(
   parameter int PRESC_W = 11,
   parameter int CNT_W   = 5
);
   logic               tick;
   logic               enable;
   logic               start;
   logic [PRESC_W-1:0] presc;
   logic [CNT_W-1:0]   count;

   modport ctrl  (output tick, output enable, output start, input presc, input count);
   modport chain (input tick, input enable, input start, output presc, output count);
endinterface

//--- design/wit_chain.sv
`include "wit_defs.svh"

module wit_chain #(
   parameter int PRESC_W = 11,
   parameter int CNT_W   = 5
) (
   // Clock and reset
   input  wire logic   clock_in,
   input  wire logic   arst_n_in,
   // Chain control and values
   wit_chain_if.chain  chain_if
);

   logic [PRESC_W-1:0] presc_reg;
   logic [CNT_W-1:0]   count_reg;
   logic               step;

   // ***********************************************************************
   // Prescaler
   // ***********************************************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         presc_reg <= '0;
      end else if (!chain_if.enable) begin
         presc_reg <= '0;
      end else if (chain_if.tick) begin
         presc_reg <= presc_reg + PRESC_W'(1);
      end
   end

   // ***********************************************************************
   // Five-bit counter, stepped by the prescaler tap
   // ***********************************************************************
   assign step = chain_if.tick && (&presc_reg[`WIT_COUNTER_TAP-1:0]);

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         count_reg <= '0;
      end else if (!chain_if.enable || !chain_if.start) begin
         count_reg <= '0;
      end else if (step) begin
         count_reg <= count_reg + CNT_W'(1);
      end
   end

   assign chain_if.presc = presc_reg;
   assign chain_if.count = count_reg;

endmodule

//--- design/wit_top.sv
`include "wit_defs.svh"

module wit_top #(
   parameter int PRESC_W = 11,
   parameter int CNT_W   = 5
) (
   // Clock and reset
   input  wire logic        clock_in,
   input  wire logic        arst_n_in,
   // Watch clock sources
   input  wire logic        sub_osc_clk_in,
   input  wire logic        divided_clk_in,
   // APB slave
   input  wire logic [31:0] paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   input  wire logic [3:0]  pstrb_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Interrupts and event pulses
   output logic             irq_out,
   output logic             watch_period_irq_out,
   output logic             interval_period_irq_out
);

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   wit_chain_if #(.PRESC_W(PRESC_W), .CNT_W(CNT_W)) chain_if ();

   logic [7:0]  watch_timer_mode_reg;
   logic [2:0]  status_reg;
   logic [2:0]  status_next;
   logic [2:0]  irq_enable_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;
   logic        irq_reg;
   logic        watch_irq_reg;
   logic        interval_irq_reg;
   logic        sub_prev_reg;
   logic        div_prev_reg;
   logic        watch_tick;
   logic        watch_hit;
   logic        interval_hit;
   logic        count_hit;
   logic        bus_setup;
   logic        bus_commit;
   logic        wr_mode;
   logic        wr_clear;
   logic        wr_irq_en;
   logic [2:0]  event_set;
   logic [2:0]  event_clear;
   logic [3:0]  interval_exp;

   wit_pkg::wit_flag_type   flag_sel;
   wit_pkg::wit_source_type src_sel;

   // ***********************************************************************
   // Helpers
   // ***********************************************************************
   // True when the low exp bits of the prescaler are all ones, so the
   // next watch clock completes a period of 2^exp.
   function automatic logic tap_hit(input logic [PRESC_W-1:0] value,
                                    input logic [3:0]         exp);
      logic [PRESC_W-1:0] mask;
      mask = PRESC_W'((32'h1 << exp) - 32'h1);
      return (value & mask) == mask;
   endfunction

   function automatic logic addr_is(input logic [31:0] addr,
                                    input logic [31:0] target);
      return addr == target;
   endfunction

   function automatic logic addr_known(input logic [31:0] addr);
      return addr_is(addr, `WIT_MODE_ADDR) || addr_is(addr, `WIT_STATUS_ADDR) ||
             addr_is(addr, `WIT_CLEAR_ADDR) || addr_is(addr, `WIT_IRQ_EN_ADDR);
   endfunction

   // ***********************************************************************
   // Mode field decode
   // ***********************************************************************
   assign src_sel      = wit_pkg::wit_source_type'(watch_timer_mode_reg[`WIT_SOURCE_BIT]);
   assign flag_sel     = wit_pkg::wit_flag_type'(
                            watch_timer_mode_reg[`WIT_FLAG_MSB:`WIT_FLAG_LSB]);
   assign interval_exp = 4'(`WIT_EXP_BASE) +
                         {1'b0, watch_timer_mode_reg[`WIT_EXP_MSB:`WIT_EXP_LSB]};

   // ***********************************************************************
   // Watch clock selection
   // ***********************************************************************
   // Both sources are sampled every cycle so a source switch while stopped
   // never produces a false edge from a stale history bit.
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sub_prev_reg <= 1'b0;
         div_prev_reg <= 1'b0;
      end else begin
         sub_prev_reg <= sub_osc_clk_in;
         div_prev_reg <= divided_clk_in;
      end
   end

   always_comb begin
      case (src_sel)
         wit_pkg::WIT_SRC_SUB_OSC: watch_tick = sub_osc_clk_in && !sub_prev_reg;
         wit_pkg::WIT_SRC_DIVIDED: watch_tick = divided_clk_in && !div_prev_reg;
         default:                  watch_tick = 1'b0;
      endcase
   end

   // ***********************************************************************
   // Prescaler and counter chain
   // ***********************************************************************
   assign chain_if.tick   = watch_tick;
   assign chain_if.enable = watch_timer_mode_reg[`WIT_ENABLE_BIT];
   assign chain_if.start  = watch_timer_mode_reg[`WIT_START_BIT];

   wit_chain #(
      .PRESC_W  (PRESC_W),
      .CNT_W    (CNT_W)
   ) u_chain (
      .clock_in (clock_in),
      .arst_n_in(arst_n_in),
      .chain_if (chain_if.chain)
   );

   // ***********************************************************************
   // Period detection
   // ***********************************************************************
   // Both detectors look at the shared chain in the same cycle.
   always_comb begin
      interval_hit = watch_tick && chain_if.enable &&
                     tap_hit(chain_if.presc, interval_exp);
      count_hit    = watch_tick && chain_if.enable &&
                     tap_hit(chain_if.presc, 4'(`WIT_COUNTER_TAP));
      watch_hit    = 1'b0;
      if (watch_tick && chain_if.enable && chain_if.start) begin
         case (flag_sel)
            wit_pkg::WIT_FLAG_2P14: watch_hit = count_hit && (&chain_if.count);
            wit_pkg::WIT_FLAG_2P13: watch_hit = count_hit &&
                                                (&chain_if.count[CNT_W-2:0]);
            wit_pkg::WIT_FLAG_2P5:  watch_hit = tap_hit(chain_if.presc,
                                                        4'(`WIT_FLAG_SHORT_TAP));
            wit_pkg::WIT_FLAG_2P4:  watch_hit = tap_hit(chain_if.presc,
                                                        4'(`WIT_FLAG_MIN_TAP));
            default:                watch_hit = 1'b0;
         endcase
      end
   end

   // ***********************************************************************
   // Request pulses
   // ***********************************************************************
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         watch_irq_reg    <= 1'b0;
         interval_irq_reg <= 1'b0;
      end else begin
         watch_irq_reg    <= watch_hit;
         interval_irq_reg <= interval_hit;
      end
   end

   // ***********************************************************************
   // APB access decode
   // ***********************************************************************
   // Zero wait states: pready rises in the first access cycle, so every
   // transfer commits at its second edge.
   assign bus_setup  = psel_in && !penable_in;
   assign bus_commit = psel_in && penable_in && pready_reg;
   assign wr_mode    = bus_commit && pwrite_in && pstrb_in[0] &&
                       addr_is(paddr_in, `WIT_MODE_ADDR);
   assign wr_clear   = bus_commit && pwrite_in && pstrb_in[0] &&
                       addr_is(paddr_in, `WIT_CLEAR_ADDR);
   assign wr_irq_en  = bus_commit && pwrite_in && pstrb_in[0] &&
                       addr_is(paddr_in, `WIT_IRQ_EN_ADDR);

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg  <= bus_setup;
         pslverr_reg <= bus_setup && !addr_known(paddr_in);
      end
   end

   // ***********************************************************************
   // Mode register
   // ***********************************************************************
   // Bit writes by software arrive as whole-byte read-modify-write, so a
   // single byte lane covers both access widths. No lockout on bits 7:2:
   // software keeps them still while the timer runs.
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         watch_timer_mode_reg <= `WIT_MODE_RESET;
      end else if (wr_mode) begin
         watch_timer_mode_reg <= pwdata_in[7:0];
      end
   end

   // ***********************************************************************
   // Interrupt status, clear and enable
   // ***********************************************************************
   assign event_set   = {count_hit && chain_if.start, interval_hit, watch_hit};
   assign event_clear = wr_clear ? pwdata_in[2:0] : 3'h0;

   // A new event in the clearing cycle stays set.
   assign status_next = (status_reg & ~event_clear) | event_set;

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         status_reg <= `WIT_STATUS_RESET;
      end else begin
         status_reg <= status_next;
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_enable_reg <= `WIT_IRQ_EN_RESET;
      end else if (wr_irq_en) begin
         irq_enable_reg <= pwdata_in[2:0];
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= |(status_next & irq_enable_reg);
      end
   end

   // ***********************************************************************
   // Read data
   // ***********************************************************************
   // Read data is latched in the setup cycle; the clear register reads zero.
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         prdata_reg <= 32'h0;
      end else if (bus_setup && !pwrite_in) begin
         if (addr_is(paddr_in, `WIT_MODE_ADDR)) begin
            prdata_reg <= {24'h0, watch_timer_mode_reg};
         end else if (addr_is(paddr_in, `WIT_STATUS_ADDR)) begin
            prdata_reg <= {29'h0, status_reg};
         end else if (addr_is(paddr_in, `WIT_IRQ_EN_ADDR)) begin
            prdata_reg <= {29'h0, irq_enable_reg};
         end else begin
            prdata_reg <= 32'h0;
         end
      end
   end

   // ***********************************************************************
   // Outputs
   // ***********************************************************************
   assign prdata_out              = prdata_reg;
   assign pready_out              = pready_reg;
   assign pslverr_out             = pslverr_reg;
   assign irq_out                 = irq_reg;
   assign watch_period_irq_out    = watch_irq_reg;
   assign interval_period_irq_out = interval_irq_reg;

endmodule

//--- tb/wit_top_chk.sv
`include "wit_defs.svh"

module wit_top_chk (
   // Clock and reset
   input wire logic        clock_in,
   input wire logic        arst_n_in,
   // Watch clock sources
   input wire logic        sub_osc_clk_in,
   input wire logic        divided_clk_in,
   // APB slave
   input wire logic [31:0] paddr_in,
   input wire logic        psel_in,
   input wire logic        penable_in,
   input wire logic        pwrite_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0]  pstrb_in,
   input wire logic [31:0] prdata_out,
   input wire logic        pready_out,
   input wire logic        pslverr_out,
   // Interrupts and event pulses
   input wire logic        irq_out,
   input wire logic        watch_period_irq_out,
   input wire logic        interval_period_irq_out
);
   // ***********************************************************************
   // Shadow copies of the writable registers
   // ***********************************************************************
   logic [7:0] mode_reg;
   logic [2:0] en_reg;
   logic       wr_ok;
   logic       mapped;
   assign wr_ok  = psel_in && penable_in && pready_out && pwrite_in && pstrb_in[0];
   assign mapped = paddr_in inside {`WIT_MODE_ADDR, `WIT_STATUS_ADDR, `WIT_CLEAR_ADDR,
                                    `WIT_IRQ_EN_ADDR};
   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         mode_reg <= 8'h00;
         en_reg   <= 3'h0;
      end else if (wr_ok && paddr_in == `WIT_MODE_ADDR) begin
         mode_reg <= pwdata_in[7:0];
      end else if (wr_ok && paddr_in == `WIT_IRQ_EN_ADDR) begin
         en_reg <= pwdata_in[2:0];
      end
   end

   // ***********************************************************************
   // Properties
   // ***********************************************************************
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);

   setup_ready_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("no ready after setup");
   idle_ready_a: assert property (!psel_in || penable_in |=> !pready_out)
      else $error("ready outside access phase");
   unmapped_err_a: assert property (psel_in && !penable_in && !pwrite_in && !mapped
      |=> pslverr_out && prdata_out == 32'h0) else $error("unmapped access not refused");
   watch_pulse_a: assert property (watch_period_irq_out |=> !watch_period_irq_out)
      else $error("watch pulse too long");
   interval_pulse_a: assert property (interval_period_irq_out |=> !interval_period_irq_out)
      else $error("interval pulse too long");
   interval_gate_a: assert property (interval_period_irq_out |-> mode_reg[0] || $past(mode_reg[0]))
      else $error("interval pulse while stopped");
   watch_gate_a: assert property (watch_period_irq_out
      |-> mode_reg[1:0] == 2'h3 || $past(mode_reg[1:0]) == 2'h3) else $error("watch pulse stopped");
   irq_raise_a: assert property (interval_period_irq_out && en_reg[1] |-> ##[1:2] irq_out)
      else $error("interrupt not raised");
   irq_mask_a: assert property (irq_out |-> en_reg != 3'h0 || $past(en_reg) != 3'h0)
      else $error("interrupt while masked");
endmodule

//--- tb/wit_top_bench.sv
`include "wit_defs.svh"

module wit_top_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] mode; int intv; int wch;} wit_row_type;
   // Mode with run bits set, interval period, watch period in ticks
   wit_row_type rows [8] = '{'{8'h0F, 16, 16}, '{8'h9B, 32, 32}, '{8'h2F, 64, 16},
      '{8'hBB, 128, 32}, '{8'h4F, 256, 16}, '{8'hDB, 512, 32}, '{8'h67, 1024, 8192},
      '{8'hF3, 2048, 16384}};
   logic        clock_in       = 1'b0;
   logic        arst_n_in      = 1'b0;
   logic        sub_osc_clk_in = 1'b0;
   logic        divided_clk_in = 1'b0;
   logic [31:0] paddr_in       = 32'h0;
   logic [31:0] pwdata_in      = 32'h0;
   logic        psel_in        = 1'b0;
   logic        penable_in     = 1'b0;
   logic        pwrite_in      = 1'b0;
   logic [3:0]  pstrb_in       = 4'h0;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        irq_out;
   logic        watch_period_irq_out;
   logic        interval_period_irq_out;
   logic [31:0] rd;
   logic        er;
   logic        src_sel = 1'b0;
   int          err_total = 0;
   int          tests_run = 0;
   int          cycles = 0;
   int          n_w = 0;
   int          n_i = 0;

   wit_top wit_top_i (.clock_in, .arst_n_in, .sub_osc_clk_in, .divided_clk_in, .paddr_in,
      .psel_in, .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
      .pslverr_out, .irq_out, .watch_period_irq_out, .interval_period_irq_out);

   initial begin
      forever #12.5 clock_in = ~clock_in;
   end

   // ***********************************************************************
   // Tasks
   // ***********************************************************************
   task automatic end_of_test();
      if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clock_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      pstrb_in <= s;
      @(posedge clock_in);
      penable_in <= 1'b1;
      // Slave sets its own pace; only the run timeout bounds this
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // Source is sampled, so each phase lasts one full cycle
   task automatic ticks(input int n);
      repeat (n) begin
         @(posedge clock_in);
         if (src_sel) divided_clk_in <= 1'b1;
         else sub_osc_clk_in <= 1'b1;
         @(posedge clock_in);
         divided_clk_in <= 1'b0;
         sub_osc_clk_in <= 1'b0;
      end
      repeat (4) @(posedge clock_in);
   endtask

   always @(posedge clock_in) begin
      cycles++;
      if (watch_period_irq_out === 1'b1) n_w++;
      if (interval_period_irq_out === 1'b1) n_i++;
      if (cycles == 90000) begin
         err_total++;
         end_of_test();
      end
   end

   // ***********************************************************************
   // Main sequence
   // ***********************************************************************
   initial begin
      int b_w;
      int b_i;
      int t;
      repeat (4) @(posedge clock_in);
      arst_n_in <= 1'b1;
      apb(1'b0, `WIT_MODE_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      chk({31'h0, er}, 32'h0);
      apb(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      apb(1'b1, `WIT_IRQ_EN_ADDR, 32'h2, 4'hF);
      foreach (rows[r]) begin
         src_sel = rows[r].mode[7];
         t = (rows[r].wch > rows[r].intv) ? rows[r].wch : rows[r].intv;
         apb(1'b1, `WIT_MODE_ADDR, 32'h0, 4'hF);
         apb(1'b1, `WIT_MODE_ADDR, {24'h0, rows[r].mode & 8'hFC}, 4'hF);
         apb(1'b1, `WIT_MODE_ADDR, {24'h0, rows[r].mode}, 4'hF);
         b_w = n_w;
         b_i = n_i;
         ticks(t - 1);
         chk(n_i - b_i, (t - 1) / rows[r].intv);
         chk(n_w - b_w, (t - 1) / rows[r].wch);
         ticks(1);
         chk(n_i - b_i, t / rows[r].intv);
         chk(n_w - b_w, t / rows[r].wch);
      end
      chk({31'h0, irq_out}, 32'h1);
      apb(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h7);
      apb(1'b1, `WIT_IRQ_EN_ADDR, 32'h0, 4'hF);
      repeat (3) @(posedge clock_in);
      chk({31'h0, irq_out}, 32'h0);
      apb(1'b1, `WIT_STATUS_ADDR, 32'h0, 4'hF);
      apb(1'b1, `WIT_CLEAR_ADDR, 32'h7, 4'hF);
      apb(1'b0, `WIT_STATUS_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      apb(1'b0, 32'h0FFFF690, 32'h0, 4'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      // Prescaler alone: interval runs, watch waits for the start bit
      src_sel = 1'b0;
      apb(1'b1, `WIT_MODE_ADDR, 32'h0, 4'hF);
      apb(1'b1, `WIT_MODE_ADDR, 32'h0D, 4'hF);
      b_w = n_w;
      b_i = n_i;
      ticks(32);
      chk(n_i - b_i, 2);
      chk(n_w - b_w, 0);
      apb(1'b1, `WIT_MODE_ADDR, 32'h0, 4'h0);
      apb(1'b0, `WIT_MODE_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0D);
      apb(1'b1, `WIT_MODE_ADDR, rd | 32'h2, 4'h1);
      ticks(16);
      chk(n_w - b_w, 1);
      // Mid-run reset must clear the running mode register
      @(posedge clock_in);
      arst_n_in <= 1'b0;
      @(posedge clock_in);
      arst_n_in <= 1'b1;
      apb(1'b0, `WIT_MODE_ADDR, 32'h0, 4'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule

bind wit_top wit_top_chk wit_top_chk_i (.clock_in, .arst_n_in, .sub_osc_clk_in, .divided_clk_in,
   .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
   .pslverr_out, .irq_out, .watch_period_irq_out, .interval_period_irq_out);
